// >>> verilog/ssb_regbank.sv
`timescale 1ns/10ps
module ssb_regbank
   import ssb_pkg::*;
(
   input  wire logic       i_clk,       // System clock, 100 MHz
   input  wire logic       i_reset,     // Synchronous reset, active high
   input  wire logic       i_sclk,      // Serial clock pin
   input  wire logic       i_cs_n,      // Chip select pin, active low
   input  wire logic       i_sdi,       // Serial data in
   output logic            o_sdo,       // Serial data out
   output logic            o_sdo_oe_n,  // Data out enable, low drives
   output logic [3:0]      o_switch     // Switch closed controls
);
   // ===========================================================
   // Pin synchronisation and edge finding
   ssb_pins_t  pins_raw;
   ssb_pins_t  pins_s;
   logic       sclk_d;
   logic       cs_n_d;

   // Raw pins bundled under a named wire so the port sees a typed value
   assign pins_raw = '{sclk: i_sclk, cs_n: i_cs_n, sdi: i_sdi};

   ssb_sync u_sync (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_pins  (pins_raw),
      .o_pins  (pins_s)
   );

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sclk_d <= 1'b0;
         cs_n_d <= 1'b1;
      end else begin
         sclk_d <= pins_s.sclk;
         cs_n_d <= pins_s.cs_n;
      end
   end

   // ===========================================================
   // Register and frame state
   ssb_state_t  state;
   logic [3:0]  switch_ctl;
   logic [2:0]  err_cfg;
   logic [2:0]  err_flags;
   logic        burst_en;
   logic [7:0]  sw_key;
   logic        key_armed;
   logic        crc_mode;
   logic        burst_q;
   logic [4:0]  pos;
   logic [1:0]  frames;
   logic [22:0] rx;
   logic [7:0]  crc;
   logic [7:0]  tx;

   // Address decode, used to check both read and write commands
   function automatic logic addr_exists(input logic [6:0] a);
      return (a == ADDR_SWITCH) || (a == ADDR_ERR_CFG) || (a == ADDR_ERR_STAT) ||
             (a == ADDR_CONSEC) || (a == ADDR_SW_KEY);
   endfunction : addr_exists

   function automatic logic addr_read_only(input logic [6:0] a);
      return a == ADDR_ERR_STAT;
   endfunction : addr_read_only

   // ===========================================================
   // Decoding of edges, frame position and commands
   wire        active     = (state == SSB_SHIFT);
   wire        sclk_rise  = active & pins_s.sclk & ~sclk_d;
   wire        sclk_fall  = active & ~pins_s.sclk & sclk_d;
   wire        cs_fall    = ~pins_s.cs_n & cs_n_d;
   wire        cs_rise    = active & pins_s.cs_n & ~cs_n_d;
   wire [4:0]  frame_len  = crc_mode ? LEN_CRC : LEN_PLAIN;
   wire [4:0]  pos_inc    = pos + 5'h01;
   wire        frame_end  = sclk_rise & (pos_inc == frame_len);
   wire [23:0] full       = {rx, pins_s.sdi};
   wire [15:0] cmd        = crc_mode ? full[23:8] : full[15:0];
   wire [7:0]  crc_rx     = full[7:0];
   // Only the first frame counts unless burst mode was on at select
   wire        gate       = burst_q | (frames == 2'b00);
   wire        crc_bad    = frame_end & gate & crc_mode & (crc_rx != crc);
   wire        cmd_ok     = frame_end & gate & ~crc_bad;
   wire [6:0]  cmd_addr   = cmd[14:8];
   wire [7:0]  cmd_data   = cmd[7:0];
   wire        cmd_write  = ~cmd[BIT_READ];
   wire        is_clear   = (cmd == CMD_CLEAR);
   wire        addr_good  = addr_exists(cmd_addr) &
                            ~(cmd_write & addr_read_only(cmd_addr));
   wire        bad_addr   = cmd_ok & ~is_clear & ~addr_good;
   wire        do_write   = cmd_ok & ~is_clear & addr_good & cmd_write;
   wire        key_hit    = do_write & (cmd_addr == ADDR_SW_KEY);
   wire        soft_rst   = key_hit & key_armed & (cmd_data == KEY_SECOND);
   // Clock count judged when select rises
   wire        count_bad  = burst_q ? ((pos != 5'h00) | (frames == 2'b00))
                                    : ((pos != 5'h00) | (frames != 2'b01));

   // Serial CRC over the 16 command bits, restarted every frame
   wire [7:0]  crc_base   = (pos == 5'h00) ? 8'h00 : crc;
   wire [7:0]  next_crc   = {crc_base[6:0], 1'b0} ^
                            ((crc_base[7] ^ pins_s.sdi) ? CRC_POLY : 8'h00);

   // Read data for the header just received, reserved bits zero
   wire [6:0]  hdr_addr   = rx[6:0];
   wire [7:0]  rdata      = (hdr_addr == ADDR_SWITCH)   ? {4'h0, switch_ctl} :
                            (hdr_addr == ADDR_ERR_CFG)  ? {5'h00, err_cfg}   :
                            (hdr_addr == ADDR_ERR_STAT) ? {5'h00, err_flags} :
                            (hdr_addr == ADDR_CONSEC)   ? {7'h00, burst_en}  :
                            (hdr_addr == ADDR_SW_KEY)   ? sw_key : 8'h00;

   // Flag events; a set in the same cycle as a clear wins
   wire [2:0]  flag_set;
   assign flag_set[BIT_CRC]  = crc_bad;
   assign flag_set[BIT_CLK]  = cs_rise & count_bad & err_cfg[BIT_CLK];
   assign flag_set[BIT_ADDR] = bad_addr & err_cfg[BIT_ADDR];
   wire [2:0]  flag_clr  = (cmd_ok & is_clear) ? 3'h7 : 3'h0;
   wire [2:0]  next_flags = (err_flags & ~flag_clr) | flag_set;

   // ===========================================================
   // Frame tracking
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state    <= SSB_IDLE;
         pos      <= 5'h00;
         frames   <= 2'b00;
         crc_mode <= 1'b0;
         burst_q  <= 1'b0;
         rx       <= '0;
         crc      <= 8'h00;
      end else if (cs_fall) begin
         state    <= SSB_SHIFT;
         pos      <= 5'h00;
         frames   <= 2'b00;
         crc_mode <= err_cfg[BIT_CRC];
         burst_q  <= burst_en;
      end else begin
         unique case (state)
            SSB_IDLE: begin
               state <= SSB_IDLE;
            end
            SSB_SHIFT: begin
               if (cs_rise) begin
                  state <= SSB_IDLE;
               end else if (sclk_rise) begin
                  rx  <= full[22:0];
                  pos <= frame_end ? 5'h00 : pos_inc;
                  if (pos < LEN_PLAIN) begin
                     crc <= next_crc;
                  end
                  if (frame_end && frames != 2'b11) begin
                     frames <= frames + 2'b01;
                  end
               end
            end
         endcase
      end
   end

   // Output shifter: alignment byte, then data of the addressed register
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         tx         <= 8'h00;
         o_sdo_oe_n <= 1'b1;
      end else if (cs_fall) begin
         tx         <= SDO_ALIGN;
         o_sdo_oe_n <= 1'b0;
      end else if (cs_rise) begin
         o_sdo_oe_n <= 1'b1;
      end else if (sclk_fall) begin
         tx <= (pos == POS_HEADER) ? rdata :
               (pos == 5'h00)      ? SDO_ALIGN : {tx[6:0], 1'b0};
      end
   end
   assign o_sdo = tx[7];

   // ===========================================================
   // Register file; a rejected command changes only the error flags and, for a bad address, the key sequence
   always_ff @(posedge i_clk) begin
      if (i_reset || soft_rst) begin
         switch_ctl <= RST_SWITCH;
         err_cfg    <= RST_ERR_CFG;
         err_flags  <= RST_ERR_STAT;
         burst_en   <= RST_CONSEC;
         sw_key     <= RST_SW_KEY;
         key_armed  <= 1'b0;
      end else begin
         err_flags <= next_flags;
         if (do_write && cmd_addr == ADDR_SWITCH) begin
            switch_ctl <= cmd_data[3:0];
         end
         if (do_write && cmd_addr == ADDR_ERR_CFG) begin
            err_cfg <= cmd_data[2:0];
         end
         if (do_write && cmd_addr == ADDR_CONSEC) begin
            burst_en <= cmd_data[0];
         end
         if (key_hit) begin
            sw_key <= cmd_data;
         end
         // Any other accepted command breaks the key sequence
         if (cmd_ok) begin
            key_armed <= key_hit & (cmd_data == KEY_FIRST);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_switch <= RST_SWITCH;
      end else begin
         o_switch <= switch_ctl;
      end
   end

   // ===========================================================
   // Checks
   sequence s_frame_close;
      cs_rise && count_bad;
   endsequence

   sequence s_key_pair;
      key_hit && key_armed && cmd_data == KEY_SECOND;
   endsequence

   chk_switch_follow: assert property (@(posedge i_clk) disable iff (i_reset)
      ##1 o_switch == $past(switch_ctl))
      else $error("switch outputs do not follow register");
   chk_reserved_zero: assert property (@(posedge i_clk) disable iff (i_reset)
      (sclk_fall && pos == POS_HEADER && hdr_addr == ADDR_ERR_CFG) |=> tx[7:3] == 5'h00)
      else $error("reserved config bits read nonzero");
   chk_config_reset: assert property (@(posedge i_clk)
      i_reset |=> err_cfg == 3'h6 && o_switch == 4'h0)
      else $error("config reset value wrong");
   chk_frame_length: assert property (@(posedge i_clk) disable iff (i_reset)
      frame_end |-> pos == (crc_mode ? 5'h17 : 5'h0F))
      else $error("frame length wrong");
   chk_count_flag: assert property (@(posedge i_clk) disable iff (i_reset || soft_rst)
      (s_frame_close and (err_cfg[BIT_CLK] == 1'b1)) |=> err_flags[BIT_CLK])
      else $error("clock count error not flagged");
   chk_count_quiet: assert property (@(posedge i_clk) disable iff (i_reset)
      (cs_rise && burst_q && pos == 5'h00 && frames != 2'b00) |-> !flag_set[BIT_CLK])
      else $error("valid burst total flagged");
   chk_status_reset: assert property (@(posedge i_clk)
      i_reset |=> err_flags == 3'h0)
      else $error("status reset value wrong");
   chk_clear_cmd: assert property (@(posedge i_clk) disable iff (i_reset)
      (cmd_ok && is_clear) |=> err_flags[BIT_ADDR] == 1'b0 && err_flags[BIT_CRC] == 1'b0)
      else $error("clear command did not clear flags");
   chk_burst_gate: assert property (@(posedge i_clk) disable iff (i_reset)
      !(cmd_ok && !burst_q && frames != 2'b00))
      else $error("second command accepted outside burst");
   chk_soft_reset: assert property (@(posedge i_clk) disable iff (i_reset)
      s_key_pair |=> err_cfg == 3'h6 && switch_ctl == 4'h0 && !burst_en ##1 o_switch == 4'h0)
      else $error("software reset did not restore defaults");
   chk_invalid_hold: assert property (@(posedge i_clk) disable iff (i_reset)
      bad_addr |=> $stable(switch_ctl) && $stable(err_cfg) && $stable(burst_en))
      else $error("invalid access changed a register");
   chk_addr_flag: assert property (@(posedge i_clk) disable iff (i_reset)
      (bad_addr && err_cfg[BIT_ADDR]) |=> err_flags[BIT_ADDR])
      else $error("invalid address not flagged");
endmodule : ssb_regbank

// >>> verilog/ssb_pkg.sv
package ssb_pkg;
   // ===========================================================
   // Register offsets (7-bit address field of a command)
   localparam logic [6:0] ADDR_SWITCH   = 7'h01;
   localparam logic [6:0] ADDR_ERR_CFG  = 7'h02;
   localparam logic [6:0] ADDR_ERR_STAT = 7'h03;
   localparam logic [6:0] ADDR_CONSEC   = 7'h05;
   localparam logic [6:0] ADDR_SW_KEY   = 7'h0B;

   // ===========================================================
   // Reset values
   localparam logic [3:0] RST_SWITCH   = 4'h0;
   localparam logic [2:0] RST_ERR_CFG  = 3'h6;
   localparam logic [2:0] RST_ERR_STAT = 3'h0;
   localparam logic       RST_CONSEC   = 1'b0;
   localparam logic [7:0] RST_SW_KEY   = 8'h00;

   // ===========================================================
   // Field positions in the config and status registers
   localparam int BIT_CRC  = 0;
   localparam int BIT_CLK  = 1;
   localparam int BIT_ADDR = 2;

   // ===========================================================
   // Frame layout and special commands
   localparam logic [4:0]  LEN_PLAIN   = 5'h10;
   localparam logic [4:0]  LEN_CRC     = 5'h18;
   localparam logic [4:0]  POS_HEADER  = 5'h08;
   localparam int          BIT_READ    = 15;
   localparam logic [15:0] CMD_CLEAR   = 16'h6CA9;
   localparam logic [7:0]  KEY_FIRST   = 8'hA3;
   localparam logic [7:0]  KEY_SECOND  = 8'h05;
   localparam logic [7:0]  SDO_ALIGN   = 8'h25;
   localparam logic [7:0]  CRC_POLY    = 8'h07;

   // Serial pins as one bundle
   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic sdi;
   } ssb_pins_t;

   typedef enum logic [1:0] {
      SSB_IDLE  = 2'b00,
      SSB_SHIFT = 2'b01
   } ssb_state_t;
endpackage : ssb_pkg

// >>> verilog/ssb_sync.sv
`timescale 1ns/10ps
// ===========================================================
// Two-flop synchroniser for the serial pins
module ssb_sync
   import ssb_pkg::*;
(
   input  wire logic      i_clk,    // System clock
   input  wire logic      i_reset,  // Synchronous reset
   input  wire ssb_pins_t i_pins,   // Raw pins
   output ssb_pins_t      o_pins    // Synchronised pins
);
   ssb_pins_t meta;

   // Idle level: chip select high, clock low
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         meta   <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
         o_pins <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
      end else begin
         meta   <= i_pins;
         o_pins <= meta;
      end
   end
endmodule : ssb_sync

// >>> sim/ssb_host.sv
`timescale 1ns/10ps
// ===========================================================
// Serial controller model: mode 0, eight system clocks per half period
module ssb_host
   import ssb_pkg::*;
(
   input  wire logic i_clk,   // System clock
   input  wire logic i_sdo,   // Serial data from the device
   output ssb_pins_t o_pins   // Serial pins towards the device
);
   // Idle bus: select high, clock low
   initial o_pins = '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};

   // Check byte over the 16 command bits, MSB first
   function automatic logic [7:0] crc8(input logic [15:0] cmd);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ cmd[i]) ? CRC_POLY : 8'h00);
      return c;
   endfunction : crc8

   // One select frame; tx is left aligned, data changes only while the clock is low
   task automatic frame(input logic [47:0] tx, input int nbits, output logic [47:0] rx);
      rx = '0;
      @(posedge i_clk) o_pins.cs_n <= 1'b0;
      for (int i = 0; i < nbits; i++) begin
         o_pins.sdi <= tx[47-i];
         repeat (8) @(posedge i_clk);
         o_pins.sclk <= 1'b1;
         rx[47-i] = i_sdo;
         repeat (8) @(posedge i_clk);
         o_pins.sclk <= 1'b0;
      end
      repeat (8) @(posedge i_clk);
      o_pins.cs_n <= 1'b1;
      o_pins.sdi  <= ~o_pins.sdi;  // Released line never repeats the last bit
      repeat (16) @(posedge i_clk);
   endtask : frame

   // Whole command: 16 bits, or 24 with the check byte; bad flips one check bit on purpose
   task automatic command(input logic [15:0] c, input logic crc_mode, input logic bad,
                          output logic [7:0] resp);
      logic [47:0] rx;
      frame({c, crc8(c) ^ {7'h00, bad}, 24'h000000}, crc_mode ? 24 : 16, rx);
      resp = rx[39:32];
   endtask : command
endmodule : ssb_host

// >>> sim/ssb_regbank_tb_top.sv
`timescale 1ns/10ps
// ===========================================================
// Register bank bench: every access goes through the serial host model
module ssb_regbank_tb_top
   import ssb_pkg::*;
;
   logic       clk;
   logic       reset;
   ssb_pins_t  pins;
   logic       sdo;
   logic       sdo_oe_n;
   // Pull-up on the data line: reads only pass while the device really drives it
   wire        sdo_line = sdo_oe_n ? 1'b1 : sdo;
   logic [3:0] sw;
   logic       crc_on;
   logic [7:0] resp;
   logic [47:0] rx;
   int         fail_count;
   int         num_checks;
   logic [6:0] ra [5] = '{ADDR_SWITCH, ADDR_ERR_CFG, ADDR_ERR_STAT, ADDR_CONSEC, ADDR_SW_KEY};
   logic [7:0] rv [5] = '{8'h00, 8'h06, 8'h00, 8'h00, 8'h00};

   ssb_regbank uut (
      .i_clk      (clk),
      .i_reset    (reset),
      .i_sclk     (pins.sclk),
      .i_cs_n     (pins.cs_n),
      .i_sdi      (pins.sdi),
      .o_sdo      (sdo),
      .o_sdo_oe_n (sdo_oe_n),
      .o_switch   (sw)
   );
   ssb_host host (
      .i_clk  (clk),
      .i_sdo  (sdo_line),
      .o_pins (pins)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ===========================================================
   // Comparison, access and closing tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host.command({1'b0, a, d}, crc_on, 1'b0, resp);
   endtask : wr

   task automatic rd(input logic [6:0] a);
      host.command({1'b1, a, 8'h00}, crc_on, 1'b0, resp);
   endtask : rd

   task automatic clr();
      host.command(CMD_CLEAR, crc_on, 1'b0, resp);
   endtask : clr

   task automatic done(input string n);
      $display("Test finished: %s", n);
   endtask : done

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict

   // Hang guard: a frame lasts a few hundred cycles, the run far less than this
   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      give_verdict();
   end

   // ===========================================================
   // Main sequence
   initial begin
      reset = 1'b1;
      crc_on = 1'b0;
      fail_count = 0;
      num_checks = 0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      repeat (4) @(posedge clk);
      foreach (ra[i]) begin
         rd(ra[i]);
         check(resp, rv[i]);
      end
      check({4'h0, sw}, 8'h00);
      done("reset values");
      // Switch bits and reserved positions, written with junk above the fields
      wr(ADDR_SWITCH, 8'h05);
      check({4'h0, sw}, 8'h05);
      wr(ADDR_SWITCH, 8'hFA);
      rd(ADDR_SWITCH);
      check(resp, 8'h0A);
      wr(ADDR_ERR_CFG, 8'hFE);
      rd(ADDR_ERR_CFG);
      check(resp, 8'h06);
      done("switch and reserved");
      // Bad address and read-only write, then the clear command
      wr(7'h04, 8'h01);
      wr(ADDR_ERR_STAT, 8'h07);
      check({4'h0, sw}, 8'h0A);
      rd(ADDR_ERR_STAT);
      check(resp, 8'h04);
      clr();
      rd(ADDR_ERR_STAT);
      check(resp, 8'h00);
      // Long frame still writes, short frame never does; both flag the count
      host.frame({1'b0, ADDR_SWITCH, 8'h03, 32'h0}, 17, rx);
      check({4'h0, sw}, 8'h03);
      rd(ADDR_ERR_STAT);
      check(resp, 8'h02);
      clr();
      host.frame({1'b0, ADDR_SWITCH, 8'h0C, 32'h0}, 15, rx);
      check({4'h0, sw}, 8'h03);
      rd(ADDR_ERR_STAT);
      check(resp, 8'h02);
      clr();
      wr(ADDR_ERR_CFG, 8'h02);
      wr(7'h04, 8'h00);
      rd(ADDR_ERR_STAT);
      check(resp, 8'h00);
      wr(ADDR_ERR_CFG, 8'h06);
      done("error flags");
      // Two commands in one select frame, then a leftover half command
      wr(ADDR_CONSEC, 8'h01);
      rd(ADDR_CONSEC);
      check(resp, 8'h01);
      host.frame({1'b0, ADDR_SWITCH, 8'h06, 1'b0, ADDR_ERR_CFG, 8'h06, 16'h0}, 32, rx);
      check({4'h0, sw}, 8'h06);
      rd(ADDR_ERR_STAT);
      check(resp, 8'h00);
      host.frame({1'b0, ADDR_SWITCH, 8'h09, 1'b0, ADDR_SWITCH, 8'h09, 16'h0}, 40, rx);
      check({4'h0, sw}, 8'h09);
      rd(ADDR_ERR_STAT);
      check(resp, 8'h02);
      clr();
      wr(ADDR_CONSEC, 8'h00);
      done("burst");
      // 24-bit frames with a good and a broken check byte
      wr(ADDR_ERR_CFG, 8'h07);
      crc_on = 1'b1;
      wr(ADDR_SWITCH, 8'h09);
      check({4'h0, sw}, 8'h09);
      host.command({1'b0, ADDR_SWITCH, 8'h01}, 1'b1, 1'b1, resp);
      check({4'h0, sw}, 8'h09);
      rd(ADDR_ERR_STAT);
      check(resp, 8'h01);
      clr();
      rd(ADDR_ERR_STAT);
      check(resp, 8'h00);
      wr(ADDR_ERR_CFG, 8'h06);
      crc_on = 1'b0;
      done("check byte");
      // Interrupted key sequence does nothing, a consecutive one restores defaults
      wr(ADDR_SW_KEY, KEY_FIRST);
      wr(ADDR_SWITCH, 8'h0F);
      wr(ADDR_SW_KEY, KEY_SECOND);
      check({4'h0, sw}, 8'h0F);
      wr(ADDR_ERR_CFG, 8'h00);
      wr(ADDR_SW_KEY, KEY_FIRST);
      wr(ADDR_SW_KEY, KEY_SECOND);
      check({4'h0, sw}, 8'h00);
      rd(ADDR_ERR_CFG);
      check(resp, 8'h06);
      done("software reset");
      give_verdict();
   end
endmodule : ssb_regbank_tb_top
